// ---- logic/fdhrp_pkg.sv ----
// Purpose: constants for the floppy host register port
// Assumes: pclk at 200 MHz, APB with 32-bit data
// Notes: rate clocks arrive as pins and are divided here
// How it works
// - host strobes count only with select, DMA grant or a load decode low
// - selected read drives data or status
// - selected write latches bus into buffer
// - select line high data, low status
// - main status readable at any moment
// - four result status registers kept
// - rate register takes two low bits
// - 32 MHz adds 1M; 16 MHz three rates
// - 9.6 MHz clock gives 300 kb/s
// - mode restricting to 150 FM/300 MFM
// - precompensation on, disable, 125 or 187 ns
// - seeks overlap on up to four drives
// - DMA or programmed transfer selectable
// - interrupt and DMA request gated
// - host accesses need no wait states
// - step and head times programmable over APB
// - DMA grant acts as data register access
// - rate decode with write loads rate
// - ops decode with write loads ops register
// - reset idles, clears outputs, base mode
package fdhrp_pkg;
  localparam logic [11:0] OFS_CONFIG = 12'h000;
  localparam logic [11:0] OFS_MSR = 12'h004;
  localparam logic [11:0] OFS_TO_HOST = 12'h008;
  localparam logic [11:0] OFS_FROM_HOST = 12'h00c;
  localparam logic [11:0] OFS_HOST_REGS = 12'h010;
  localparam logic [11:0] OFS_EVENTS = 12'h014;
  localparam logic [11:0] OFS_TIMING = 12'h018;
  localparam logic [11:0] OFS_REQ = 12'h01c;
  localparam logic [11:0] OFS_RESULT0 = 12'h020;
  localparam logic [11:0] OFS_RESULT3 = 12'h02c;
  // config and ops bit positions
  localparam int CFG_EXT = 0;
  localparam int CFG_PDOWN = 1;
  localparam int CFG_PIO = 2;
  localparam int CFG_RESTRICT = 3;
  localparam int CFG_MFM = 4;
  localparam int CFG_PRE_DIS = 5;
  localparam int CFG_SLOW = 6;
  localparam int OPS_DMA_GATE = 3;
  // event bit positions
  localparam int EV_HOST_WR = 0;
  localparam int EV_HOST_RD = 1;
  localparam int EV_BAD_WR = 2;
  localparam int EV_OPS = 3;
  localparam int EV_RATE = 4;
  // reset values
  localparam logic [6:0] CONFIG_RST = 7'h00;
  localparam logic [7:0] MSR_RST = 8'h80;
  localparam logic [1:0] RATE_500 = 2'h0;
  localparam logic [1:0] RATE_300 = 2'h1;
  localparam logic [1:0] RATE_250 = 2'h2;
  localparam logic [1:0] RATE_1M = 2'h3;
  localparam logic [1:0] RATE_RST = RATE_500;
  // divide ratios as powers of two of the source clock
  localparam logic [3:0] DIV_32 = 4'h5;
  localparam logic [3:0] DIV_64 = 4'h6;
  localparam logic [3:0] DIV_128 = 4'h7;
  localparam logic [3:0] DIV_256 = 4'h8;
  // precompensation shift
  localparam int PCLK_MHZ = 200;
  localparam int PRE_SHORT_NS = 125;
  localparam int PRE_LONG_NS = 187;
  localparam int PRE_SHORT_CYC = PRE_SHORT_NS * PCLK_MHZ / 1000;
  localparam int PRE_LONG_CYC = PRE_LONG_NS * PCLK_MHZ / 1000;
endpackage

// ---- logic/fdhrp_rate_gen.sv ----
// Purpose: divides sampled rate clock edges into a bit-rate tick
// Assumes: src_edge is a one-cycle pulse per source clock rise
// Notes: divide ratio is two to the power div_log
module fdhrp_rate_gen
  import fdhrp_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src_edge,
  input wire logic [3:0] div_log,
  output logic tick
);
  initial begin
    if (CNT_W < 8 || CNT_W > 15) begin
      $error("fdhrp_rate_gen: CNT_W out of range");
    end
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } fdhrp_gen_t;

  fdhrp_gen_t r;
  fdhrp_gen_t next_r;
  logic [CNT_W:0] full;

  always_comb begin
    next_r = r;
    full = ((CNT_W+1)'(1) << div_log) - (CNT_W+1)'(1);
    next_r.tick = 1'b0;
    if (src_edge) begin
      if (r.cnt >= full[CNT_W-1:0]) begin
        next_r.cnt = '0;
        next_r.tick = 1'b1;
      end else begin
        next_r.cnt = r.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;
endmodule

// ---- logic/fdhrp_top.sv ----
// Purpose: host register port of a floppy subsystem controller
// Assumes: host pins are asynchronous and pass two flip-flops
// Notes: formatter side reaches the port over APB
module fdhrp_top
  import fdhrp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic register_select_line,
  input wire logic dma_grant_input_n,
  input wire logic rate_reg_load_decode_n,
  input wire logic ops_reg_load_decode_n,
  input wire logic [7:0] db_in,
  output logic [7:0] db_out,
  output logic db_oe,
  input wire logic dual_speed_drive_input,
  input wire logic precomp_long_sel,
  input wire logic primary_is_32mhz,
  input wire logic primary_rate_clock,
  input wire logic alt_rate_clock,
  output logic irq_out,
  output logic irq_oe,
  output logic drq_out,
  output logic drq_oe,
  output logic [1:0] rate_code,
  output logic alt_clock_used,
  output logic rate_tick,
  output logic precomp_enable,
  output logic [5:0] precomp_shift,
  output logic [3:0] drive_seeking,
  output logic [3:0] step_rate,
  output logic [3:0] head_unload,
  output logic [6:0] head_load
);
  typedef struct packed {
    logic [1:0] cs_n_s;
    logic [1:0] rd_n_s;
    logic [1:0] wr_n_s;
    logic [1:0] a0_s;
    logic [1:0] dma_grant_input_n_s;
    logic [1:0] rate_reg_load_decode_n_s;
    logic [1:0] ops_reg_load_decode_n_s;
    logic [1:0] drv_s;
    logic [1:0] pcl_s;
    logic [1:0] c32_s;
    logic [1:0][7:0] db_s;
    logic [2:0] primary_rate_clock_s;
    logic [2:0] alt_rate_clock_s;
    logic [1:0] strap_cnt;
    logic is32;
    logic rd_act;
    logic wr_act;
    logic wr_a0;
    logic rate_reg_load_decode_act;
    logic ops_reg_load_decode_act;
    logic [7:0] wr_hold;
    logic [7:0] db_out;
    logic db_oe;
    logic [6:0] config_bits;
    logic [7:0] msr;
    logic [7:0] to_host;
    logic [7:0] from_host;
    logic [1:0] rate;
    logic [7:0] ops;
    logic [7:0] msr1;
    logic [4:0] events;
    logic [14:0] timing;
    logic [1:0] req;
    logic [3:0][7:0] result;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic irq;
    logic irq_oe;
    logic drq;
    logic drq_oe;
    logic use_alt;
    logic [3:0] div_log;
    logic precomp_en;
    logic [5:0] pre_shift;
  } fdhrp_state_t;

  fdhrp_state_t r;
  fdhrp_state_t next_r;
  logic sel;
  logic dma_grant_input;
  logic host_rd;
  logic host_wr;
  logic a0_eff;
  logic ld_rate;
  logic ld_ops;
  logic ext;
  logic apb_wr;
  logic [4:0] ev_set;
  logic [4:0] ev_clr;
  logic [1:0] idx;
  logic src_edge;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    ev_set = '0;
    ev_clr = '0;
    idx = paddr[3:2];
    // pin synchronisers, first stage read only by second
    next_r.cs_n_s = {r.cs_n_s[0], cs_n};
    next_r.rd_n_s = {r.rd_n_s[0], rd_n};
    next_r.wr_n_s = {r.wr_n_s[0], wr_n};
    next_r.a0_s = {r.a0_s[0], register_select_line};
    next_r.dma_grant_input_n_s = {r.dma_grant_input_n_s[0], dma_grant_input_n};
    next_r.rate_reg_load_decode_n_s = {r.rate_reg_load_decode_n_s[0], rate_reg_load_decode_n};
    next_r.ops_reg_load_decode_n_s = {r.ops_reg_load_decode_n_s[0], ops_reg_load_decode_n};
    next_r.drv_s = {r.drv_s[0], dual_speed_drive_input};
    next_r.pcl_s = {r.pcl_s[0], precomp_long_sel};
    next_r.c32_s = {r.c32_s[0], primary_is_32mhz};
    next_r.db_s = {r.db_s[0], db_in};
    next_r.primary_rate_clock_s = {r.primary_rate_clock_s[1:0], primary_rate_clock};
    next_r.alt_rate_clock_s = {r.alt_rate_clock_s[1:0], alt_rate_clock};
    // strap taken once the synchroniser holds the pin
    if (r.strap_cnt != 2'h3) begin
      next_r.strap_cnt = r.strap_cnt + 2'h1;
    end
    if (r.strap_cnt == 2'h2) begin
      next_r.is32 = r.c32_s[1];
    end

    ////////////////////////////////////////////////////////////////////
    // host strobe decode
    ext = r.config_bits[CFG_EXT];
    sel = !r.cs_n_s[1];
    dma_grant_input = !r.dma_grant_input_n_s[1] && (!ext || r.ops[OPS_DMA_GATE]);
    a0_eff = dma_grant_input || r.a0_s[1];
    host_rd = !r.rd_n_s[1] && (sel || dma_grant_input);
    host_wr = !r.wr_n_s[1] && (sel || dma_grant_input);
    ld_rate = !r.wr_n_s[1] && !r.rate_reg_load_decode_n_s[1];
    ld_ops = !r.wr_n_s[1] && !r.ops_reg_load_decode_n_s[1];

    // read drives data or status, bus released otherwise
    next_r.db_oe = host_rd;
    if (host_rd) begin
      next_r.db_out = a0_eff ? r.to_host : r.msr;
    end
    next_r.rd_act = host_rd;
    if (host_rd && !r.rd_act && a0_eff) begin
      ev_set[EV_HOST_RD] = 1'b1;
    end

    // write data held while strobe low, committed at its end
    if (!r.wr_n_s[1]) begin
      next_r.wr_hold = r.db_s[1];
    end
    next_r.wr_act = host_wr;
    if (host_wr) begin
      next_r.wr_a0 = a0_eff;
    end
    if (r.wr_act && !host_wr) begin
      if (r.wr_a0) begin
        next_r.from_host = r.wr_hold;
        ev_set[EV_HOST_WR] = 1'b1;
      end else if (r.config_bits[CFG_PDOWN]) begin
        next_r.msr1 = r.wr_hold;
      end else begin
        ev_set[EV_BAD_WR] = 1'b1;
      end
    end
    next_r.rate_reg_load_decode_act = ld_rate;
    if (r.rate_reg_load_decode_act && !ld_rate) begin
      next_r.rate = r.wr_hold[1:0];
      ev_set[EV_RATE] = 1'b1;
    end
    next_r.ops_reg_load_decode_act = ld_ops;
    if (r.ops_reg_load_decode_act && !ld_ops) begin
      next_r.ops = r.wr_hold;
      ev_set[EV_OPS] = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // data rate source and divide selection
    next_r.use_alt = 1'b0;
    if (r.config_bits[CFG_RESTRICT]) begin
      next_r.use_alt = 1'b1;
      next_r.div_log = r.config_bits[CFG_MFM] ? DIV_32 : DIV_64;
    end else begin
      case (r.rate)
        RATE_500: next_r.div_log = r.is32 ? DIV_64 : DIV_32;
        RATE_300: begin
          if (r.drv_s[1]) begin
            next_r.use_alt = 1'b1;
            next_r.div_log = DIV_32;
          end else begin
            next_r.div_log = r.is32 ? DIV_128 : DIV_64;
          end
        end
        RATE_250: begin
          if (r.config_bits[CFG_SLOW]) begin
            next_r.div_log = r.is32 ? DIV_256 : DIV_128;
          end else begin
            next_r.div_log = r.is32 ? DIV_128 : DIV_64;
          end
        end
        default: next_r.div_log = r.is32 ? DIV_32 : DIV_128;
      endcase
    end

    // precompensation
    next_r.precomp_en = !r.config_bits[CFG_PRE_DIS];
    next_r.pre_shift = r.pcl_s[1] ? 6'(PRE_LONG_CYC) : 6'(PRE_SHORT_CYC);

    // request gating
    next_r.irq = r.req[0];
    next_r.drq = r.req[1] && !r.config_bits[CFG_PIO];
    next_r.irq_oe = !ext || r.ops[OPS_DMA_GATE];
    next_r.drq_oe = !ext || r.ops[OPS_DMA_GATE];

    ////////////////////////////////////////////////////////////////////
    // APB slave, answer in the first access cycle
    next_r.pready = psel && !penable;
    apb_wr = psel && penable && r.pready && pwrite;
    // error flag stands with ready only
    next_r.pslverr = 1'b0;
    if (psel && !penable) begin
      next_r.prdata = '0;
      next_r.pslverr = 1'b0;
      if (paddr == OFS_CONFIG) begin
        next_r.prdata = {25'h0, r.config_bits};
      end else if (paddr == OFS_MSR) begin
        next_r.prdata = {24'h0, r.msr};
      end else if (paddr == OFS_TO_HOST) begin
        next_r.prdata = {24'h0, r.to_host};
      end else if (paddr == OFS_FROM_HOST) begin
        next_r.prdata = {24'h0, r.from_host};
      end else if (paddr == OFS_HOST_REGS) begin
        next_r.prdata = {8'h0, r.msr1, r.ops, 6'h0, r.rate};
      end else if (paddr == OFS_EVENTS) begin
        next_r.prdata = {27'h0, r.events};
      end else if (paddr == OFS_TIMING) begin
        next_r.prdata = {17'h0, r.timing};
      end else if (paddr == OFS_REQ) begin
        next_r.prdata = {30'h0, r.req};
      end else if (paddr >= OFS_RESULT0 && paddr <= OFS_RESULT3 &&
                   paddr[1:0] == 2'h0) begin
        next_r.prdata = {24'h0, r.result[idx]};
      end else begin
        next_r.pslverr = 1'b1;
      end
    end
    if (apb_wr) begin
      if (paddr == OFS_CONFIG) begin
        next_r.config_bits = pwdata[6:0];
      end else if (paddr == OFS_MSR) begin
        next_r.msr = pwdata[7:0];
      end else if (paddr == OFS_TO_HOST) begin
        next_r.to_host = pwdata[7:0];
      end else if (paddr == OFS_EVENTS) begin
        ev_clr = pwdata[4:0];
      end else if (paddr == OFS_TIMING) begin
        next_r.timing = pwdata[14:0];
      end else if (paddr == OFS_REQ) begin
        next_r.req = pwdata[1:0];
      end else if (paddr >= OFS_RESULT0 && paddr <= OFS_RESULT3 &&
                   paddr[1:0] == 2'h0) begin
        next_r.result[idx] = pwdata[7:0];
      end
    end
    // set wins over clear
    next_r.events = (r.events & ~ev_clr) | ev_set;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.cs_n_s <= '1;
      r.rd_n_s <= '1;
      r.wr_n_s <= '1;
      r.dma_grant_input_n_s <= '1;
      r.rate_reg_load_decode_n_s <= '1;
      r.ops_reg_load_decode_n_s <= '1;
      r.drv_s <= '1;
      r.config_bits <= CONFIG_RST;
      r.msr <= MSR_RST;
      r.rate <= RATE_RST;
      r.div_log <= DIV_32;
    end else begin
      r <= next_r;
    end
  end

  assign src_edge = r.use_alt ? (r.alt_rate_clock_s[1] && !r.alt_rate_clock_s[2])
                              : (r.primary_rate_clock_s[1] && !r.primary_rate_clock_s[2]);

  fdhrp_rate_gen #(
    .CNT_W(8)
  ) u_rate_gen (
    .pclk(pclk),
    .presetn(presetn),
    .src_edge(src_edge),
    .div_log(r.div_log),
    .tick(rate_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs from state flops
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign db_out = r.db_out;
  assign db_oe = r.db_oe;
  assign irq_out = r.irq;
  assign irq_oe = r.irq_oe;
  assign drq_out = r.drq;
  assign drq_oe = r.drq_oe;
  assign rate_code = r.rate;
  assign alt_clock_used = r.use_alt;
  assign precomp_enable = r.precomp_en;
  assign precomp_shift = r.pre_shift;
  assign drive_seeking = r.msr[3:0];
  assign step_rate = r.timing[3:0];
  assign head_unload = r.timing[7:4];
  assign head_load = r.timing[14:8];
endmodule

// ---- test/fdhrp_host_model.sv ----
// Purpose: host processor bus model
// Assumes: strobes held at least four pclk cycles
// Notes: floating bus shows inverted last value
module fdhrp_host_model (
  input wire logic pclk,
  input wire logic [7:0] db_out,
  input wire logic db_oe,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic register_select_line,
  output logic dma_grant_input_n,
  output logic rate_reg_load_decode_n,
  output logic ops_reg_load_decode_n,
  output wire logic [7:0] db_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic [7:0] hd = 8'h00;
  logic [7:0] last = 8'h00;
  initial begin
    {cs_n, rd_n, wr_n, dma_grant_input_n} = 4'hf;
    {rate_reg_load_decode_n, ops_reg_load_decode_n} = 2'h3;
    register_select_line = 1'b0;
  end
  assign db_in = db_oe ? db_out : (drv ? hd : ~last);
  always @(posedge pclk) last <= db_in;
  // how: [0] select [1] grant [2] rate decode [3] ops decode
  task automatic access(input logic rd, input logic sel,
    input logic [3:0] how, input logic [7:0] d, output logic [7:0] q);
    @(posedge pclk);
    cs_n <= !how[0];
    dma_grant_input_n <= !how[1];
    rate_reg_load_decode_n <= !how[2];
    ops_reg_load_decode_n <= !how[3];
    register_select_line <= sel;
    hd <= d;
    drv <= !rd;
    if (rd) rd_n <= 1'b0;
    else wr_n <= 1'b0;
    repeat (5) @(posedge pclk);
    q = db_in;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (4) @(posedge pclk);
    {cs_n, dma_grant_input_n} <= 2'h3;
    {rate_reg_load_decode_n, ops_reg_load_decode_n} <= 2'h3;
    drv <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// ---- test/fdhrp_monitor.sv ----
// Purpose: port checker for fdhrp_top
// Assumes: host pins change on pclk edges
// Notes: bound to every fdhrp_top instance
module fdhrp_monitor
  import fdhrp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic register_select_line,
  input wire logic dma_grant_input_n,
  input wire logic [7:0] db_out,
  input wire logic db_oe,
  input wire logic [1:0] rate_code,
  input wire logic [3:0] step_rate,
  input wire logic [3:0] drive_seeking,
  input wire logic precomp_enable,
  input wire logic [5:0] precomp_shift,
  input wire logic precomp_long_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  property p_sel;
    $rose(db_oe) |-> !$past(cs_n) || !$past(dma_grant_input_n);
  endproperty
  a_sel:
    assert property (p_sel) else $error("bus driven without select");
  property p_drive;
    $rose(db_oe) |-> !$past(rd_n) && !$past(rd_n, 2);
  endproperty
  a_drive:
    assert property (p_drive) else $error("bus driven without read");
  property p_release;
    $rose(rd_n) |-> ##[0:5] !db_oe;
  endproperty
  a_release:
    assert property (p_release) else $error("bus not released");
  property p_nowait;
    psel && !penable ##1 psel && penable |-> pready;
  endproperty
  a_nowait:
    assert property (p_nowait) else $error("access not wait free");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse:
    assert property (p_pulse) else $error("ready longer than one cycle");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err:
    assert property (p_err) else $error("error without ready");
  property p_rst;
    !$past(presetn) |-> rate_code == RATE_RST && step_rate == 4'h0;
  endproperty
  a_rst:
    assert property (p_rst) else $error("bad state after reset");
  property p_status;
    db_oe && !register_select_line && !cs_n && dma_grant_input_n
      |-> db_out[3:0] == drive_seeking;
  endproperty
  a_status:
    assert property (p_status) else $error("status byte wrong");
  property p_shift;
    precomp_enable && $stable(precomp_long_sel) [*4] |-> precomp_shift ==
      (precomp_long_sel ? 6'(PRE_LONG_CYC) : 6'(PRE_SHORT_CYC));
  endproperty
  a_shift:
    assert property (p_shift) else $error("precomp shift wrong");
endmodule
bind fdhrp_top fdhrp_monitor i_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .cs_n(cs_n), .rd_n(rd_n), .register_select_line(register_select_line),
  .dma_grant_input_n(dma_grant_input_n), .db_out(db_out), .db_oe(db_oe),
  .rate_code(rate_code), .step_rate(step_rate),
  .drive_seeking(drive_seeking), .precomp_enable(precomp_enable),
  .precomp_shift(precomp_shift), .precomp_long_sel(precomp_long_sel));

// ---- test/fdhrp_top_bench.sv ----
// Purpose: self-checking bench for fdhrp_top
// Assumes: APB master and host model tasks
// Notes: rate clocks divided from pclk
module fdhrp_top_bench;
  import fdhrp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, db_oe, precomp_long_sel = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic cs_n, rd_n, wr_n, sel, gnt_n, rdec_n, odec_n, e;
  logic [7:0] db_in, db_out, hq;
  logic irq_out, irq_oe, drq_out, drq_oe, alt_clock_used, precomp_enable;
  logic rate_tick;
  logic [1:0] rate_code;
  logic [5:0] precomp_shift;
  logic [3:0] drive_seeking, step_rate, head_unload;
  logic [6:0] head_load;
  logic [4:0] div = 5'h00;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  fdhrp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .register_select_line(sel),
    .dma_grant_input_n(gnt_n), .rate_reg_load_decode_n(rdec_n),
    .ops_reg_load_decode_n(odec_n), .db_in(db_in), .db_out(db_out),
    .db_oe(db_oe), .dual_speed_drive_input(1'b1),
    .precomp_long_sel(precomp_long_sel), .primary_is_32mhz(1'b1),
    .primary_rate_clock(div[1]), .alt_rate_clock(div[4]),
    .irq_out(irq_out), .irq_oe(irq_oe), .drq_out(drq_out),
    .drq_oe(drq_oe), .rate_code(rate_code),
    .alt_clock_used(alt_clock_used), .rate_tick(rate_tick),
    .precomp_enable(precomp_enable), .precomp_shift(precomp_shift),
    .drive_seeking(drive_seeking), .step_rate(step_rate),
    .head_unload(head_unload), .head_load(head_load));
  fdhrp_host_model i_host (.pclk(pclk), .db_out(db_out), .db_oe(db_oe),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .register_select_line(sel),
    .dma_grant_input_n(gnt_n), .rate_reg_load_decode_n(rdec_n),
    .ops_reg_load_decode_n(odec_n), .db_in(db_in));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    div <= div + 5'h01;
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
    input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [11:0] a,
    input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, q);
  endtask
  task automatic hrd(input string nm, input logic s, input logic [3:0] h,
    input logic [7:0] x);
    i_host.access(1'b1, s, h, 8'h00, hq);
    chk(nm, {24'h0, x}, {24'h0, hq});
  endtask
  task automatic hwr(input logic s, input logic [3:0] h, input logic [7:0] d);
    i_host.access(1'b0, s, h, d, hq);
  endtask
  // cycles between two rate ticks
  task automatic gap(input string nm, input int x);
    int n;
    n = 0;
    repeat (4) @(posedge pclk);
    while (rate_tick !== 1'b1) begin
      @(posedge pclk);
    end
    @(posedge pclk);
    while (rate_tick !== 1'b1) begin
      n++;
      @(posedge pclk);
    end
    chk(nm, 32'(x), 32'(n + 1));
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rdc("config", OFS_CONFIG, 32'h0);
    rdc("msr", OFS_MSR, 32'h80);
    rdc("host_regs", OFS_HOST_REGS, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    apb(1'b1, OFS_MSR, 32'h85);
    hrd("status_rd", 1'b0, 4'h1, 8'h85);
    apb(1'b1, OFS_TO_HOST, 32'h5a);
    hrd("data_rd", 1'b1, 4'h1, 8'h5a);
    hrd("grant_rd", 1'b0, 4'h2, 8'h5a);
    hwr(1'b1, 4'h1, 8'hc3);
    rdc("from_host", OFS_FROM_HOST, 32'hc3);
    hwr(1'b1, 4'h0, 8'h11);
    rdc("no_select", OFS_FROM_HOST, 32'hc3);
    apb(1'b1, OFS_EVENTS, 32'h1f);
    hwr(1'b0, 4'h1, 8'h22);
    rdc("bad_event", OFS_EVENTS, 32'h04);
    rdc("bad_kept", OFS_FROM_HOST, 32'hc3);
    apb(1'b1, OFS_CONFIG, 32'h02);
    hwr(1'b0, 4'h1, 8'h77);
    rdc("pdown_wr", OFS_HOST_REGS, 32'h770000);
    apb(1'b1, OFS_CONFIG, 32'h00);
    for (int i = 0; i < 4; i++) begin
      hwr(1'b1, 4'h4, 8'hfc | 8'(i));
      chk("rate_code", 32'(i), {30'h0, rate_code});
      chk("alt_used", 32'(i == 1), {31'h0, alt_clock_used});
    end
    gap("rate_1m", 4 << DIV_32);
    hwr(1'b1, 4'h8, 8'ha5);
    rdc("ops", OFS_HOST_REGS, 32'h77a503);
    apb(1'b1, OFS_TIMING, 32'h7f5a);
    @(posedge pclk);
    chk("timing", 32'h7f5a, {17'h0, head_load, head_unload, step_rate});
    apb(1'b1, OFS_REQ, 32'h3);
    repeat (2) @(posedge pclk);
    chk("req", 32'hf, {28'h0, irq_oe, irq_out, drq_oe, drq_out});
    precomp_long_sel <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("shift", 32'(PRE_LONG_CYC), {26'h0, precomp_shift});
    apb(1'b1, OFS_CONFIG, 32'h20);
    repeat (4) @(posedge pclk);
    chk("pre_off", 32'h0, {31'h0, precomp_enable});
    apb(1'b1, OFS_CONFIG, 32'h18);
    gap("restrict_mfm", 32 << DIV_32);
    chk("alt_restrict", 32'h1, {31'h0, alt_clock_used});
    final_report();
  end
endmodule
